// [src/nts_host.v]
// Overview of operation
// - read strobe falls at least 20 ns after ready/busy rises.
// - read strobe falls at least 15 ns after address latch select falls.
// - read strobe falls at least 15 ns after command latch select falls.
// - at least 60 ns from command write strobe rise to read strobe fall.
// - at least 100 ns from last address strobe rise to first data rise.
// - in cache read, read strobe stays high at least 100 ns.
// - write-protect changes at least 100 ns before next write strobe rise; a supply drop mid-operation pulls it low at once, with no such wait.
// - a data-input burst carries at most 2112 bytes.
// - status read is command 70h then a read strobe returning status.
// - write-protect held low while supply is not in nominal range.
`timescale 1ns/1ps
`default_nettype none
`include "nts_map.vh"
module nts_host #(
   parameter ADDR_CYCLES    = 5,
   parameter PROG_BUSY_CYC  = `NTS_US_FLOOR_CYC(`NTS_PROGRAM_BUSY_US),
   parameter ERASE_BUSY_CYC = `NTS_US_FLOOR_CYC(`NTS_ERASE_BUSY_US),
   parameter CACHE_BUSY_CYC = `NTS_US_FLOOR_CYC(`NTS_CACHE_BUSY_US)
) (
   input  wire        CLK_SYS,
   input  wire        SRST,
   input  wire        OP_VALID,
   input  wire [2:0]  OP_CODE,
   input  wire [39:0] OP_ADDR,
   input  wire [11:0] OP_LEN,
   output reg         OP_READY,
   input  wire [7:0]  WR_DATA,
   input  wire        WR_VALID,
   output reg         WR_TAKEN,
   output reg  [7:0]  RD_DATA,
   output reg         RD_VALID,
   output reg         OP_DONE,
   output reg         OP_TIMEOUT,
   output reg  [7:0]  OP_STATUS,
   input  wire        PROG_ERASE_ENABLE,
   input  wire        POWER_GOOD,
   output reg         NAND_CE_N,
   output reg         COMMAND_LATCH_SELECT,
   output reg         ADDRESS_LATCH_SELECT,
   output reg         NAND_WE_N,
   output reg         NAND_RE_N,
   output reg         NAND_WP_N,
   input  wire [7:0]  IO_IN,
   output reg  [7:0]  IO_OUT,
   output reg         IO_OE_N,
   input  wire        READY_BUSY_LINE
);
   // =====================================
   // timing counts
   localparam [16:0] GAP_WB    = `NTS_CEIL_CYC(`NTS_BUSY_ASSERT_DELAY_NS);
   localparam [16:0] GAP_RR    = `NTS_CEIL_CYC(`NTS_READY_TO_READ_GAP_NS);
   localparam [16:0] GAP_AR    = `NTS_CEIL_CYC(`NTS_LATCH_TO_READ_GAP_NS);
   localparam [16:0] GAP_CLR   = `NTS_CEIL_CYC(`NTS_CMD_LATCH_TO_READ_NS);
   localparam [16:0] GAP_WHR   = `NTS_CEIL_CYC(`NTS_COMMAND_TO_READ_NS);
   localparam [16:0] GAP_ADL   = `NTS_CEIL_CYC(`NTS_ADDRESS_TO_DATA_NS);
   localparam [16:0] GAP_CRRH  = `NTS_CEIL_CYC(`NTS_CACHE_READ_HOLD_NS);
   localparam [16:0] GAP_WW    = `NTS_CEIL_CYC(`NTS_PROTECT_SETTLE_NS);
   localparam [16:0] TO_READ   = `NTS_US_FLOOR_CYC(`NTS_READ_BUSY_US);
   localparam [16:0] TO_RESET  = `NTS_US_FLOOR_CYC(`NTS_RESET_IDLE_US);
   localparam [16:0] TO_PROG   = PROG_BUSY_CYC;
   localparam [16:0] TO_ERASE  = ERASE_BUSY_CYC;
   localparam [16:0] TO_CACHE  = CACHE_BUSY_CYC;
   localparam [11:0] PAGE_MAX  = `NTS_PAGE_BYTES;
   localparam [2:0]  ADDR_FULL = ADDR_CYCLES;
   localparam [2:0]  ADDR_ROW  = ADDR_CYCLES - 2;
   // =====================================
   // states
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_C1   = 4'h1;
   localparam [3:0] S_AD   = 4'h2;
   localparam [3:0] S_GAP  = 4'h3;
   localparam [3:0] S_WD   = 4'h4;
   localparam [3:0] S_C2   = 4'h5;
   localparam [3:0] S_BSY  = 4'h6;
   localparam [3:0] S_RD   = 4'h7;
   localparam [3:0] S_DONE = 4'h8;

   reg  [3:0]  state;
   reg  [3:0]  ret;
   reg         ph;
   reg  [2:0]  op;
   reg  [39:0] addr_sh;
   reg  [2:0]  addr_left;
   reg  [11:0] cnt;
   reg  [16:0] busy_max;
   reg         tmr_load;
   reg  [16:0] tmr_val;
   wire        tmr_done;
   wire        want_wp_n;

   // =====================================
   // helpers
   function [7:0] first_cmd;
      input [2:0] o;
      begin
         case (o)
            `NTS_OP_READ:       first_cmd = `NTS_CMD_READ1;
            `NTS_OP_PROG:       first_cmd = `NTS_CMD_PROG1;
            `NTS_OP_CACHE_PROG: first_cmd = `NTS_CMD_PROG1;
            `NTS_OP_ERASE:      first_cmd = `NTS_CMD_ERASE1;
            `NTS_OP_RESET:      first_cmd = `NTS_CMD_RESET;
            `NTS_OP_CACHE_READ: first_cmd = `NTS_CMD_CACHE_READ;
            default:            first_cmd = `NTS_CMD_STATUS;
         endcase
      end
   endfunction

   function [16:0] busy_limit;
      input [2:0] o;
      begin
         case (o)
            `NTS_OP_PROG:       busy_limit = TO_PROG;
            `NTS_OP_ERASE:      busy_limit = TO_ERASE;
            `NTS_OP_CACHE_PROG: busy_limit = TO_CACHE;
            `NTS_OP_RESET:      busy_limit = TO_RESET;
            default:            busy_limit = TO_READ;
         endcase
      end
   endfunction

   function is_write;
      input [2:0] o;
      begin
         is_write = (o == `NTS_OP_PROG) || (o == `NTS_OP_CACHE_PROG);
      end
   endfunction

   // supply outside nominal range forces protection
   assign want_wp_n = PROG_ERASE_ENABLE & POWER_GOOD;

   nts_timer #(
      .WIDTH (17)
   ) u_timer (
      .clk     (CLK_SYS),
      .srst    (SRST),
      .load    (tmr_load),
      .value   (tmr_val),
      .expired (tmr_done)
   );

   // =====================================
   // sequencer
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         state <= S_IDLE;
         ret <= S_IDLE;
         ph <= 1'b0;
         op <= 3'h0;
         addr_sh <= 40'h0;
         addr_left <= 3'h0;
         cnt <= 12'h0;
         busy_max <= 17'h0;
         tmr_load <= 1'b0;
         tmr_val <= 17'h0;
         OP_READY <= 1'b0;
         WR_TAKEN <= 1'b0;
         RD_DATA <= 8'h00;
         RD_VALID <= 1'b0;
         OP_DONE <= 1'b0;
         OP_TIMEOUT <= 1'b0;
         OP_STATUS <= 8'h00;
         NAND_CE_N <= 1'b1;
         COMMAND_LATCH_SELECT <= 1'b0;
         ADDRESS_LATCH_SELECT <= 1'b0;
         NAND_WE_N <= 1'b1;
         NAND_RE_N <= 1'b1;
         NAND_WP_N <= 1'b0;
         IO_OUT <= 8'h00;
         IO_OE_N <= 1'b1;
      end else begin
         tmr_load <= 1'b0;
         WR_TAKEN <= 1'b0;
         RD_VALID <= 1'b0;
         OP_DONE <= 1'b0;
         if (!POWER_GOOD) begin
            NAND_WP_N <= 1'b0;
         end
         case (state)
            S_IDLE: begin
               NAND_CE_N <= 1'b1;
               IO_OE_N <= 1'b1;
               if (NAND_WP_N != want_wp_n) begin
                  // settle before any strobe can follow
                  OP_READY <= 1'b0;
                  NAND_WP_N <= want_wp_n;
                  tmr_load <= 1'b1;
                  tmr_val <= GAP_WW;
                  ret <= S_IDLE;
                  state <= S_GAP;
               end else if (OP_VALID && OP_READY) begin
                  OP_READY <= 1'b0;
                  OP_TIMEOUT <= 1'b0;
                  op <= OP_CODE;
                  busy_max <= busy_limit(OP_CODE);
                  if (OP_CODE == `NTS_OP_ERASE) begin
                     addr_sh <= {16'h0000, OP_ADDR[39:16]};
                     addr_left <= ADDR_ROW;
                  end else begin
                     addr_sh <= OP_ADDR;
                     addr_left <= ADDR_FULL;
                  end
                  if (OP_CODE == `NTS_OP_STATUS) begin
                     cnt <= 12'h001;
                  end else if (OP_LEN > PAGE_MAX) begin
                     cnt <= PAGE_MAX;
                  end else if (OP_LEN == 12'h000) begin
                     cnt <= 12'h001;
                  end else begin
                     cnt <= OP_LEN;
                  end
                  NAND_CE_N <= 1'b0;
                  ph <= 1'b0;
                  state <= S_C1;
               end else begin
                  // serialised: offered whenever idle with protect settled; ready/busy is not checked
                  OP_READY <= 1'b1;
               end
            end
            S_C1, S_C2: begin
               if (!ph) begin
                  COMMAND_LATCH_SELECT <= 1'b1;
                  // address phase is over; both latches high would be illegal
                  ADDRESS_LATCH_SELECT <= 1'b0;
                  IO_OE_N <= 1'b0;
                  NAND_WE_N <= 1'b0;
                  if (state == S_C1) begin
                     IO_OUT <= first_cmd(op);
                  end else if (op == `NTS_OP_READ) begin
                     IO_OUT <= `NTS_CMD_READ2;
                  end else if (op == `NTS_OP_ERASE) begin
                     IO_OUT <= `NTS_CMD_ERASE2;
                  end else if (op == `NTS_OP_CACHE_PROG) begin
                     IO_OUT <= `NTS_CMD_CACHE_PROG2;
                  end else begin
                     IO_OUT <= `NTS_CMD_PROG2;
                  end
                  ph <= 1'b1;
               end else begin
                  NAND_WE_N <= 1'b1;
                  ph <= 1'b0;
                  // a stale gap equal to the assert delay would skip that wait
                  tmr_val <= 17'h0;
                  if (state == S_C1 && op == `NTS_OP_STATUS) begin
                     tmr_load <= 1'b1;
                     tmr_val <= (GAP_WHR > GAP_CLR) ? GAP_WHR : GAP_CLR;
                     ret <= S_RD;
                     state <= S_GAP;
                  end else if (state == S_C1 && (op == `NTS_OP_RESET
                               || op == `NTS_OP_CACHE_READ)) begin
                     state <= S_BSY;
                  end else if (state == S_C1) begin
                     state <= S_AD;
                  end else begin
                     state <= S_BSY;
                  end
               end
            end
            S_AD: begin
               COMMAND_LATCH_SELECT <= 1'b0;
               if (!ph) begin
                  ADDRESS_LATCH_SELECT <= 1'b1;
                  IO_OE_N <= 1'b0;
                  IO_OUT <= addr_sh[7:0];
                  NAND_WE_N <= 1'b0;
                  ph <= 1'b1;
               end else begin
                  NAND_WE_N <= 1'b1;
                  addr_sh <= {8'h00, addr_sh[39:8]};
                  addr_left <= addr_left - 3'h1;
                  ph <= 1'b0;
                  if (addr_left == 3'h1) begin
                     if (is_write(op)) begin
                        tmr_load <= 1'b1;
                        tmr_val <= GAP_ADL;
                        ret <= S_WD;
                        state <= S_GAP;
                     end else begin
                        state <= S_C2;
                     end
                  end
               end
            end
            S_GAP: begin
               COMMAND_LATCH_SELECT <= 1'b0;
               ADDRESS_LATCH_SELECT <= 1'b0;
               if (tmr_done && !tmr_load) begin
                  state <= ret;
               end
            end
            S_WD: begin
               if (!ph) begin
                  // writer may stall the burst by holding WR_VALID low
                  if (WR_VALID) begin
                     IO_OE_N <= 1'b0;
                     IO_OUT <= WR_DATA;
                     NAND_WE_N <= 1'b0;
                     WR_TAKEN <= 1'b1;
                     ph <= 1'b1;
                  end
               end else begin
                  NAND_WE_N <= 1'b1;
                  cnt <= cnt - 12'h001;
                  ph <= 1'b0;
                  if (cnt == 12'h001) begin
                     state <= S_C2;
                  end
               end
            end
            S_BSY: begin
               COMMAND_LATCH_SELECT <= 1'b0;
               IO_OE_N <= 1'b1;
               if (!ph) begin
                  // ready/busy is meaningless until the device had time to drop it
                  if (!tmr_load && tmr_val != GAP_WB) begin
                     tmr_load <= 1'b1;
                     tmr_val <= GAP_WB;
                  end else if (tmr_done && !tmr_load) begin
                     tmr_load <= 1'b1;
                     tmr_val <= busy_max;
                     ph <= 1'b1;
                  end
               end else if (!tmr_load) begin
                  if (READY_BUSY_LINE) begin
                     ph <= 1'b0;
                     tmr_val <= 17'h0;
                     if (op == `NTS_OP_READ || op == `NTS_OP_CACHE_READ) begin
                        tmr_load <= 1'b1;
                        tmr_val <= (GAP_RR > GAP_AR) ? GAP_RR : GAP_AR;
                        ret <= S_RD;
                        state <= S_GAP;
                     end else begin
                        state <= S_DONE;
                     end
                  end else if (tmr_done) begin
                     OP_TIMEOUT <= 1'b1;
                     tmr_val <= 17'h0;
                     ph <= 1'b0;
                     state <= S_DONE;
                  end
               end
            end
            S_RD: begin
               IO_OE_N <= 1'b1;
               if (!ph) begin
                  NAND_RE_N <= 1'b0;
                  ph <= 1'b1;
               end else begin
                  // sampled at the end of a 40 ns low phase
                  NAND_RE_N <= 1'b1;
                  RD_DATA <= IO_IN;
                  RD_VALID <= 1'b1;
                  cnt <= cnt - 12'h001;
                  ph <= 1'b0;
                  if (op == `NTS_OP_STATUS) begin
                     OP_STATUS <= IO_IN;
                  end
                  if (cnt == 12'h001) begin
                     state <= S_DONE;
                  end else if (op == `NTS_OP_CACHE_READ) begin
                     tmr_load <= 1'b1;
                     tmr_val <= GAP_CRRH;
                     ret <= S_RD;
                     state <= S_GAP;
                  end
               end
            end
            S_DONE: begin
               NAND_CE_N <= 1'b1;
               IO_OE_N <= 1'b1;
               OP_DONE <= 1'b1;
               state <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// [src/nts_map.vh]
`ifndef NTS_MAP_VH
`define NTS_MAP_VH
// =====================================
// clock and conversions
`define NTS_CLK_NS              40
`define NTS_CEIL_CYC(ns)        (((ns) + `NTS_CLK_NS - 1) / `NTS_CLK_NS)
`define NTS_US_FLOOR_CYC(us)    (((us) * 1000) / `NTS_CLK_NS)
// =====================================
// least gaps the host keeps, in ns
`define NTS_BUSY_ASSERT_DELAY_NS  100
`define NTS_READY_TO_READ_GAP_NS  20
`define NTS_LATCH_TO_READ_GAP_NS  15
`define NTS_CMD_LATCH_TO_READ_NS  15
`define NTS_COMMAND_TO_READ_NS    60
`define NTS_ADDRESS_TO_DATA_NS    100
`define NTS_CACHE_READ_HOLD_NS    100
`define NTS_PROTECT_SETTLE_NS     100
// =====================================
// longest busy times of the device
`define NTS_READ_BUSY_US        25
`define NTS_PROGRAM_BUSY_US     700
`define NTS_ERASE_BUSY_US       3000
`define NTS_RESET_IDLE_US       5
`define NTS_RESET_PROGRAM_US    10
`define NTS_RESET_ERASE_US      500
`define NTS_CACHE_BUSY_US       700
// =====================================
// page and commands
`define NTS_PAGE_BYTES          2112
`define NTS_CMD_READ1           8'h00
`define NTS_CMD_READ2           8'h30
`define NTS_CMD_CACHE_READ      8'h31
`define NTS_CMD_PROG1           8'h80
`define NTS_CMD_PROG2           8'h10
`define NTS_CMD_CACHE_PROG2     8'h15
`define NTS_CMD_ERASE1          8'h60
`define NTS_CMD_ERASE2          8'hD0
`define NTS_CMD_RESET           8'hFF
`define NTS_CMD_STATUS          8'h70
// =====================================
// operation codes on OP_CODE
`define NTS_OP_READ             3'h0
`define NTS_OP_PROG             3'h1
`define NTS_OP_ERASE            3'h2
`define NTS_OP_RESET            3'h3
`define NTS_OP_STATUS           3'h4
`define NTS_OP_CACHE_PROG       3'h5
`define NTS_OP_CACHE_READ       3'h6
`endif

// [src/nts_timer.v]
`timescale 1ns/1ps
`default_nettype none
// =====================================
// down counter, expired once load has settled and count hits zero
module nts_timer #(
   parameter WIDTH = 17
) (
   input  wire             clk,
   input  wire             srst,
   input  wire             load,
   input  wire [WIDTH-1:0] value,
   output wire             expired
);
   reg [WIDTH-1:0] count;

   // load masks the stale zero of the previous wait
   assign expired = ~load & (count == {WIDTH{1'b0}});

   always @(posedge clk) begin
      if (srst) begin
         count <= {WIDTH{1'b0}};
      end else if (load) begin
         count <= value;
      end else if (count != {WIDTH{1'b0}}) begin
         count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

// [verification/nts_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// =====
// clockless flash device, busy times shortened
module nts_flash_model #(
   parameter int READ_NS  = 3000,
   parameter int PROG_NS  = 1200,
   parameter int ERASE_NS = 1600,
   parameter int RST_NS   = 800,
   parameter int CACHE_NS = 400,
   parameter int SLOW_NS  = 4000
) (
   input  wire logic       ce_n,
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       we_n,
   input  wire logic       re_n,
   input  wire logic       wp_n,
   input  wire logic       slow,
   input  wire logic [7:0] io_drv,
   output logic      [7:0] io_rd,
   output logic            ready_busy,
   output logic      [7:0] last_cmd,
   output int              data_bytes
);
   logic       status_mode;
   logic [7:0] rd_cnt;
   int         busy_ns;
   event       start;
   initial begin
      io_rd = 8'h5A;
      ready_busy = 1'b1;
      last_cmd = 8'h00;
      data_bytes = 0;
      status_mode = 1'b0;
      rd_cnt = 8'h00;
      busy_ns = 0;
   end
   // =====
   // commands and data bytes
   always @(posedge we_n) begin
      if (!ce_n && cle) begin
         last_cmd = io_drv;
         status_mode = (io_drv == 8'h70);
         rd_cnt = 8'h00;
         busy_ns = 0;
         if (io_drv == 8'h80)
            data_bytes = 0;
         case (io_drv)
            8'h30: busy_ns = READ_NS;
            8'h10: busy_ns = slow ? SLOW_NS : PROG_NS;
            8'hD0: busy_ns = ERASE_NS;
            8'hFF: busy_ns = RST_NS;
            8'h15, 8'h31: busy_ns = CACHE_NS;
            default: ;
         endcase
         if (busy_ns > 0)
            -> start;
      end else if (!ce_n && !ale) begin
         data_bytes = data_bytes + 1;
      end
   end
   // busy drops well inside the assert delay
   always @(start) begin
      #60 ready_busy = 1'b0;
      #(busy_ns) ready_busy = 1'b1;
   end
   // =====
   // read data; a released bus shows the inverse, never a stale byte
   always @(negedge re_n) begin
      #20 io_rd = status_mode ? {wp_n, ready_busy, 6'h00} : 8'hA0 + rd_cnt;
      rd_cnt = rd_cnt + 8'h01;
   end
   always @(posedge re_n) #15 io_rd = ~io_rd;
endmodule
`default_nettype wire

// [verification/nts_host_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// =====
// pin timing checks of the host
module nts_host_monitor (
   input wire logic       CLK_SYS,
   input wire logic       SRST,
   input wire logic       OP_VALID,
   input wire logic [2:0] OP_CODE,
   input wire logic       OP_READY,
   input wire logic       POWER_GOOD,
   input wire logic       NAND_WE_N,
   input wire logic       NAND_RE_N,
   input wire logic       NAND_WP_N,
   input wire logic       COMMAND_LATCH_SELECT,
   input wire logic       ADDRESS_LATCH_SELECT,
   input wire logic [7:0] IO_OUT,
   input wire logic       READY_BUSY_LINE
);
   logic        cache;
   logic [11:0] nbytes;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   sequence s_re_fall;
      $fell(NAND_RE_N);
   endsequence
   sequence s_cmd_rise;
      $rose(NAND_WE_N) && COMMAND_LATCH_SELECT;
   endsequence
   sequence s_adr_rise;
      $rose(NAND_WE_N) && ADDRESS_LATCH_SELECT;
   endsequence
   // =====
   // op mode and burst count, counted at the pins not inside the host
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         cache <= 1'b0;
         nbytes <= 12'h000;
      end else begin
         if (OP_VALID && OP_READY)
            cache <= (OP_CODE == 3'h6);
         if ($rose(NAND_WE_N) && COMMAND_LATCH_SELECT)
            nbytes <= 12'h000;
         else if ($rose(NAND_WE_N) && !ADDRESS_LATCH_SELECT)
            nbytes <= nbytes + 12'h001;
      end
   end
   // =====
   // assertions
   a_ready_read: assert property ($rose(READY_BUSY_LINE) |-> NAND_RE_N [*2])
      else $error("read strobe too soon after ready");
   a_ale_read: assert property (s_re_fall |-> !$past(ADDRESS_LATCH_SELECT))
      else $error("read strobe too soon after address latch");
   a_cle_read: assert property (s_re_fall |-> !$past(COMMAND_LATCH_SELECT))
      else $error("read strobe too soon after command latch");
   a_cmd_read: assert property (s_cmd_rise |-> NAND_RE_N [*2])
      else $error("read strobe too soon after command");
   a_addr_data: assert property (s_adr_rise |=>
      (!($rose(NAND_WE_N) && !ADDRESS_LATCH_SELECT && !COMMAND_LATCH_SELECT)) [*2])
      else $error("data strobe too soon after last address");
   a_cache_hold: assert property (cache && $rose(NAND_RE_N) |-> NAND_RE_N [*3])
      else $error("read strobe high too short in cache read");
   a_wp_settle: assert property ($changed(NAND_WP_N) |-> !$rose(NAND_WE_N) [*3])
      else $error("write strobe too soon after protect change");
   a_burst_max: assert property ($rose(NAND_WE_N) && !ADDRESS_LATCH_SELECT
      && !COMMAND_LATCH_SELECT |-> nbytes < 12'h840)
      else $error("data burst too long");
   a_status_cmd: assert property (OP_VALID && OP_READY && OP_CODE == 3'h4 |-> ##[1:4]
      ($rose(NAND_WE_N) && COMMAND_LATCH_SELECT && IO_OUT == 8'h70))
      else $error("status command not sent");
   a_wp_power: assert property (!POWER_GOOD |=> !NAND_WP_N)
      else $error("protect pin high without power");
   a_idle_cmd: assert property ($rose(NAND_WE_N) && COMMAND_LATCH_SELECT
      && IO_OUT != 8'h70 && IO_OUT != 8'hFF |-> $past(READY_BUSY_LINE))
      else $error("command issued while busy");
endmodule
bind nts_host nts_host_monitor i_mon (.CLK_SYS(CLK_SYS), .SRST(SRST), .OP_VALID(OP_VALID),
   .OP_CODE(OP_CODE), .OP_READY(OP_READY), .POWER_GOOD(POWER_GOOD), .NAND_WE_N(NAND_WE_N),
   .NAND_RE_N(NAND_RE_N), .NAND_WP_N(NAND_WP_N), .COMMAND_LATCH_SELECT(COMMAND_LATCH_SELECT),
   .ADDRESS_LATCH_SELECT(ADDRESS_LATCH_SELECT), .IO_OUT(IO_OUT),
   .READY_BUSY_LINE(READY_BUSY_LINE));
`default_nettype wire

// [verification/nts_host_test.sv]
`timescale 1ns/1ps
`default_nettype none
module nts_host_test;
   logic        clk, srst, op_valid, wr_valid, pe_en, pwr_good, slow;
   logic [2:0]  op_code;
   logic [39:0] op_addr;
   logic [11:0] op_len;
   logic [7:0]  wr_data, rd_data, op_status, io_out, io_rd, last_cmd;
   logic        op_ready, wr_taken, rd_valid, op_done, op_timeout;
   logic        ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n, rb;
   wire  [7:0]  io_bus;
   int          data_bytes, failures, check_count, nrd, cycles;
   assign io_bus = io_oe_n ? io_rd : io_out;
   nts_host #(.PROG_BUSY_CYC(50), .ERASE_BUSY_CYC(50), .CACHE_BUSY_CYC(50)) i_dut (
      .CLK_SYS(clk), .SRST(srst), .OP_VALID(op_valid), .OP_CODE(op_code),
      .OP_ADDR(op_addr), .OP_LEN(op_len), .OP_READY(op_ready), .WR_DATA(wr_data),
      .WR_VALID(wr_valid), .WR_TAKEN(wr_taken), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .OP_DONE(op_done), .OP_TIMEOUT(op_timeout), .OP_STATUS(op_status),
      .PROG_ERASE_ENABLE(pe_en), .POWER_GOOD(pwr_good), .NAND_CE_N(ce_n),
      .COMMAND_LATCH_SELECT(cle), .ADDRESS_LATCH_SELECT(ale), .NAND_WE_N(we_n),
      .NAND_RE_N(re_n), .NAND_WP_N(wp_n), .IO_IN(io_bus), .IO_OUT(io_out),
      .IO_OE_N(io_oe_n), .READY_BUSY_LINE(rb));
   nts_flash_model i_dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
      .wp_n(wp_n), .slow(slow), .io_drv(io_bus), .io_rd(io_rd), .ready_busy(rb),
      .last_cmd(last_cmd), .data_bytes(data_bytes));
   // =====
   // common tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // request held until the host drops its ready
   task automatic run_op(input logic [2:0] code, input logic [11:0] len, input int nwr);
      int n;
      int g;
      n = 0;
      g = 0;
      nrd = 0;
      while (op_ready !== 1'b1 && g < 3000) begin
         @(posedge clk);
         #1 g++;
      end
      op_code = code;
      op_len = len;
      op_addr = 40'h00C0123456;
      wr_data = 8'h00;
      wr_valid = (nwr > 0);
      op_valid = 1'b1;
      do begin
         @(posedge clk);
         #1 g++;
      end while (op_ready === 1'b1 && g < 3000);
      op_valid = 1'b0;
      while (op_done !== 1'b1 && g < 20000) begin
         @(posedge clk);
         #1 g++;
         if (wr_taken === 1'b1) begin
            n++;
            wr_data = n[7:0];
            wr_valid = (n < nwr);
         end
         if (rd_valid === 1'b1) begin
            // status bytes are judged by the caller
            if (code != 3'h4)
               check(rd_data, 8'hA0 + nrd[7:0]);
            nrd++;
         end
      end
      wr_valid = 1'b0;
      check(g < 20000, 1'b1);
   endtask
   // =====
   // scenarios
   task automatic t_status(input logic [7:0] exp);
      run_op(3'h4, 12'h001, 0);
      check(op_status, exp);
      check(op_timeout, 1'b0);
      $display("test status done");
   endtask
   task automatic t_read;
      run_op(3'h0, 12'h004, 0);
      check(nrd[15:0], 16'h0004);
      check(last_cmd, 8'h30);
      $display("test read done");
   endtask
   task automatic t_prog;
      run_op(3'h1, 12'h898, 2200);
      check(data_bytes[15:0], 16'h0840);
      check(op_timeout, 1'b0);
      run_op(3'h1, 12'h000, 1);
      check(data_bytes[15:0], 16'h0001);
      $display("test program done");
   endtask
   task automatic t_timeout;
      int g;
      slow = 1'b1;
      run_op(3'h1, 12'h001, 1);
      check(op_timeout, 1'b1);
      slow = 1'b0;
      for (g = 0; g < 500 && rb !== 1'b1; g++)
         @(posedge clk);
      #1 t_status(8'hC0);
      $display("test timeout done");
   endtask
   task automatic t_cmds;
      logic [2:0] codes [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
      logic [7:0] cmds [4] = '{8'hD0, 8'hFF, 8'h15, 8'h31};
      for (int i = 0; i < 4; i++) begin
         run_op(codes[i], 12'h003, (i == 2) ? 3 : 0);
         check(last_cmd, cmds[i]);
         check(op_timeout, 1'b0);
      end
      check(nrd[15:0], 16'h0003);
      $display("test busy commands done");
   endtask
   task automatic t_protect;
      // supply drop while protection is off must force it on
      pwr_good = 1'b0;
      repeat (8) @(posedge clk);
      #1 check(wp_n, 1'b0);
      t_status(8'h40);
      pwr_good = 1'b1;
      pe_en = 1'b0;
      repeat (8) @(posedge clk);
      #1 t_status(8'h40);
      pe_en = 1'b1;
      repeat (8) @(posedge clk);
      #1 t_status(8'hC0);
      $display("test protect done");
   endtask
   task automatic t_midreset;
      srst = 1'b1;
      repeat (2) @(posedge clk);
      #1 check({wp_n, ce_n, op_ready}, 3'b010);
      srst = 1'b0;
      t_status(8'hC0);
      $display("test mid reset done");
   endtask
   // =====
   // clock, hang guard, main sequence
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // whole run needs roughly 5k cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         print_verdict;
      end
   end
   initial begin
      {srst, pe_en, pwr_good} = 3'b111;
      {op_valid, wr_valid, slow} = 3'b000;
      {op_code, op_addr, op_len, wr_data} = '0;
      {failures, check_count, nrd, cycles} = '0;
      repeat (10) @(posedge clk);
      #1 check({wp_n, ce_n, we_n, re_n, op_ready}, 5'b01110);
      srst = 1'b0;
      t_status(8'hC0);
      t_read;
      t_prog;
      t_timeout;
      t_cmds;
      t_protect;
      t_midreset;
      print_verdict;
   end
endmodule
`default_nettype wire
